// File: hdl/odgc_avmm_slave.sv
`timescale 1ns/1ps
`include "odgc_map.svh"

// Avalon-MM handshake with one wait state for every access.
module odgc_avmm_slave
	import odgc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Bus request and answer.
	input odgc_avmm_req_t req,
	output logic waitrequest,
	output logic [31:0] readdata,
	// Register file side.
	input wire logic [31:0] read_value,
	output logic write_strobe
);

	logic ack_q;

	// The request is stalled once, so read data come from a flip-flop
	// instead of a long decode path straight to the bus.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ack_q <= 1'b0;
		else
			ack_q <= (req.read | req.write) & ~ack_q;
	end

	// Read data are captured in the stalled cycle and stand until the next.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			readdata <= 32'h0000_0000;
		else if (req.read && !ack_q)
			readdata <= read_value;
	end

	assign waitrequest = (req.read | req.write) & ~ack_q;
	assign write_strobe = req.write & ack_q;

endmodule

// File: hdl/odgc_map.svh
`ifndef ODGC_MAP_SVH
`define ODGC_MAP_SVH

// Register indices; the byte address is four times the index.
`define ODGC_IDX_DIV2_COUNTS 10'h196
`define ODGC_IDX_DIV2_CTRL 10'h197
`define ODGC_IDX_CH2_PWR 10'h198
`define ODGC_IDX_DIV3_COUNTS 10'h199
`define ODGC_IDX_DIV3_CTRL 10'h19A
`define ODGC_IDX_CH3_PWR 10'h19B
`define ODGC_IDX_STATUS 10'h19C

// Register slots and groups.
`define ODGC_SLOTS 6
`define ODGC_SLOT_W 3
`define ODGC_GROUPS 2
`define ODGC_SLOTS_PER_GROUP 3
`define ODGC_OFS_COUNTS 0
`define ODGC_OFS_CTRL 1
`define ODGC_OFS_PWR 2
`define ODGC_OUTS_PER_GROUP 3

// Cycle count fields.
`define ODGC_LOW_HI 7
`define ODGC_LOW_LO 4
`define ODGC_HIGH_HI 3
`define ODGC_HIGH_LO 0

// Divider control fields.
`define ODGC_BYPASS 7
`define ODGC_IGNORE_SYNC 6
`define ODGC_FORCE_HIGH 5
`define ODGC_START_HIGH 4
`define ODGC_PHASE_HI 3
`define ODGC_PHASE_LO 0

// Power and duty fields.
`define ODGC_POWER_DOWN 2
`define ODGC_DCC_OFF 0
`define ODGC_PWR_MASK 8'h05

// Reset values.
`define ODGC_DIV2_COUNTS_RST 8'h11
`define ODGC_DIV3_COUNTS_RST 8'h00
`define ODGC_CTRL_RST 8'h00
`define ODGC_PWR_RST 8'h00

// Status bits per group: level, running.
`define ODGC_STAT_BITS 2
`endif

// File: hdl/odgc_pkg.sv
package odgc_pkg;

	// One Avalon-MM request as seen by the slave.
	typedef struct packed {
		logic read;
		logic write;
		logic [11:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} odgc_avmm_req_t;

	// Decoded settings of one divider group.
	typedef struct packed {
		logic [3:0] low_count;
		logic [3:0] high_count;
		logic bypass;
		logic ignore_sync;
		logic force_high;
		logic start_high;
		logic [3:0] phase;
		logic power_down;
		logic dcc_off;
	} odgc_cfg_t;

	// Divider sequencer states.
	typedef enum logic [1:0] {
		ODGC_HOLD,
		ODGC_DELAY,
		ODGC_RUN
	} odgc_state_t;

endpackage

// File: hdl/odgc_top.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "odgc_map.svh"

// Behaviour
// RQ1: Low phase lasts low count plus one.
// RQ2: High phase lasts high count plus one.
// RQ3: Bypass stops divider, passes clock through.
// RQ4: Ignore bit makes divider disregard sync.
// RQ5: Force bit picks static level, needs ignore.
// RQ6: Start bit sets first level after start.
// RQ7: Four-bit phase offset, reset zero.
// RQ8: Power-down floats all three group outputs.
// RQ9: Duty correction on unless disable bit set.
// RQ10: Sync holds dividers; release restarts them.
// RQ11: Restart waits phase cycles, then start level.
module odgc_top
	import odgc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Avalon-MM slave.
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Chip-level sync request, high while held, same clock domain.
	input wire logic sync_hold,
	// Divider outputs, index 0 is group 2, index 1 is group 3.
	output logic [`ODGC_GROUPS-1:0] div_clk_out,
	// Output enables, three per group, low in power-down.
	output logic [`ODGC_GROUPS*`ODGC_OUTS_PER_GROUP-1:0] out_enable,
	// Duty-cycle correction enable per group.
	output logic [`ODGC_GROUPS-1:0] duty_cycle_correction_en
);

	odgc_avmm_req_t bus_req;
	logic write_strobe;
	logic [31:0] read_value;
	logic [9:0] word_index;
	logic [7:0] cfg_q [`ODGC_SLOTS];
	odgc_cfg_t cfg [`ODGC_GROUPS];
	logic [`ODGC_GROUPS-1:0] level_q;
	logic [`ODGC_GROUPS-1:0] running;
	logic [`ODGC_GROUPS*`ODGC_STAT_BITS-1:0] status;

	// Slot of a word index in the configuration store.
	function automatic logic [`ODGC_SLOT_W-1:0] slot_of
	(
		input logic [9:0] idx
	);
		logic [9:0] diff;
		diff = idx - `ODGC_IDX_DIV2_COUNTS;
		slot_of = diff[`ODGC_SLOT_W-1:0];
	endfunction

	// Whether a word index falls on a configuration register.
	function automatic logic is_cfg
	(
		input logic [9:0] idx
	);
		is_cfg = (idx >= `ODGC_IDX_DIV2_COUNTS) &&
			(idx <= `ODGC_IDX_CH3_PWR);
	endfunction

	// Writable bits of a slot; unused power bits read as zero.
	function automatic logic [7:0] mask_of
	(
		input logic [`ODGC_SLOT_W-1:0] slot
	);
		if (slot == `ODGC_SLOT_W'(`ODGC_OFS_PWR) ||
			slot == `ODGC_SLOT_W'(`ODGC_SLOTS_PER_GROUP +
			`ODGC_OFS_PWR))
			mask_of = `ODGC_PWR_MASK;
		else
			mask_of = 8'hFF;
	endfunction

	// Pack the bus signals for the handshake module.
	assign bus_req.read = read;
	assign bus_req.write = write;
	assign bus_req.address = address;
	assign bus_req.byteenable = byteenable;
	assign bus_req.writedata = writedata;
	assign word_index = address[11:2];

	odgc_avmm_slave u_slave
	(
		.clock(clock),
		.reset_n(reset_n),
		.req(bus_req),
		.waitrequest(waitrequest),
		.readdata(readdata),
		.read_value(read_value),
		.write_strobe(write_strobe)
	);

	// Configuration store. Writes land only on the edge where
	// waitrequest is low, and only through byte lane zero; writes to
	// unmapped words and to the status word are dropped.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg_q[`ODGC_OFS_COUNTS] <= `ODGC_DIV2_COUNTS_RST;
			cfg_q[`ODGC_OFS_CTRL] <= `ODGC_CTRL_RST;
			cfg_q[`ODGC_OFS_PWR] <= `ODGC_PWR_RST;
			cfg_q[`ODGC_SLOTS_PER_GROUP + `ODGC_OFS_COUNTS] <=
				`ODGC_DIV3_COUNTS_RST;
			cfg_q[`ODGC_SLOTS_PER_GROUP + `ODGC_OFS_CTRL] <=
				`ODGC_CTRL_RST;
			cfg_q[`ODGC_SLOTS_PER_GROUP + `ODGC_OFS_PWR] <=
				`ODGC_PWR_RST;
		end
		else if (write_strobe && byteenable[0] && is_cfg(word_index))
		begin
			cfg_q[slot_of(word_index)] <=
				writedata[7:0] & mask_of(slot_of(word_index));
		end
	end

	// Read decode; narrow registers sit in the low byte.
	always_comb
	begin
		read_value = 32'h0000_0000;
		if (is_cfg(word_index))
			read_value[7:0] = cfg_q[slot_of(word_index)];
		else if (word_index == `ODGC_IDX_STATUS)
			read_value[`ODGC_GROUPS*`ODGC_STAT_BITS-1:0] = status;
	end

	genvar g;
	generate
		for (g = 0; g < `ODGC_GROUPS; g = g + 1)
		begin : g_div
			localparam int BASE = g * `ODGC_SLOTS_PER_GROUP;
			odgc_state_t state_q;
			logic [3:0] count_q;
			logic hold;
			logic forced;
			logic [3:0] limit;
			logic lvl_q;

			// Field decode of this group's three registers.
			// RQ1: low count field
			assign cfg[g].low_count =
				cfg_q[BASE + `ODGC_OFS_COUNTS]
				[`ODGC_LOW_HI:`ODGC_LOW_LO];
			// RQ2: high count field
			assign cfg[g].high_count =
				cfg_q[BASE + `ODGC_OFS_COUNTS]
				[`ODGC_HIGH_HI:`ODGC_HIGH_LO];
			assign cfg[g].bypass =
				cfg_q[BASE + `ODGC_OFS_CTRL][`ODGC_BYPASS];
			assign cfg[g].ignore_sync =
				cfg_q[BASE + `ODGC_OFS_CTRL][`ODGC_IGNORE_SYNC];
			assign cfg[g].force_high =
				cfg_q[BASE + `ODGC_OFS_CTRL][`ODGC_FORCE_HIGH];
			assign cfg[g].start_high =
				cfg_q[BASE + `ODGC_OFS_CTRL][`ODGC_START_HIGH];
			// RQ7: phase offset field
			assign cfg[g].phase =
				cfg_q[BASE + `ODGC_OFS_CTRL]
				[`ODGC_PHASE_HI:`ODGC_PHASE_LO];
			assign cfg[g].power_down =
				cfg_q[BASE + `ODGC_OFS_PWR][`ODGC_POWER_DOWN];
			assign cfg[g].dcc_off =
				cfg_q[BASE + `ODGC_OFS_PWR][`ODGC_DCC_OFF];

			// RQ4: sync obeyed unless ignored
			assign hold = sync_hold & ~cfg[g].ignore_sync;
			// RQ5: force needs ignore bit
			assign forced = cfg[g].ignore_sync & cfg[g].force_high;

			// Count limit of the phase now being driven.
			assign limit = level_q[g] ? cfg[g].high_count :
				cfg[g].low_count;

			// Sequencer. Bypass, a sync hold and a forced level all
			// park the divider; leaving any of them restarts it
			// through the phase delay, so groups released together
			// stay aligned.
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
					state_q <= ODGC_DELAY;
				else if (cfg[g].bypass || hold || forced)
					state_q <= ODGC_HOLD;
				else
				begin
					case (state_q)
						ODGC_HOLD:
							// RQ10: restart on release
							state_q <= ODGC_DELAY;
						ODGC_DELAY:
							// RQ11: wait out the offset
							if (count_q == cfg[g].phase)
								state_q <= ODGC_RUN;
						ODGC_RUN:
							state_q <= ODGC_RUN;
						default:
							state_q <= ODGC_HOLD;
					endcase
				end
			end

			// Cycle counter shared by the phase delay and both halves.
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
					count_q <= 4'h0;
				else if (cfg[g].bypass || hold || forced)
					count_q <= 4'h0;
				else
				begin
					case (state_q)
						ODGC_HOLD:
							count_q <= 4'h0;
						ODGC_DELAY:
							if (count_q == cfg[g].phase)
								count_q <= 4'h0;
							else
								count_q <= count_q + 4'h1;
						ODGC_RUN:
							// RQ1: low lasts count plus one
							// RQ2: high lasts count plus one
							if (count_q == limit)
								count_q <= 4'h0;
							else
								count_q <= count_q + 4'h1;
						default:
							count_q <= 4'h0;
					endcase
				end
			end

			// Output level. A parked divider rests low; the forced
			// level overrides that only with the ignore bit set.
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
					lvl_q <= 1'b0;
				// RQ5: static forced level
				else if (forced)
					lvl_q <= 1'b1;
				// RQ10: static while held
				else if (cfg[g].bypass || hold)
					lvl_q <= 1'b0;
				else
				begin
					case (state_q)
						ODGC_HOLD:
							lvl_q <= 1'b0;
						ODGC_DELAY:
							// RQ6: begin at start level
							if (count_q == cfg[g].phase)
								lvl_q <= cfg[g].start_high;
						ODGC_RUN:
							if (count_q == limit)
								lvl_q <= ~lvl_q;
						default:
							lvl_q <= 1'b0;
					endcase
				end
			end

			// One flip-flop per group keeps each bit to a single process.
			assign level_q[g] = lvl_q;
			assign running[g] = (state_q == ODGC_RUN);
			assign status[g*`ODGC_STAT_BITS +: `ODGC_STAT_BITS] =
				{running[g], level_q[g]};

			// The bypass path carries the clock itself, so it cannot
			// come from a flip-flop; a powered-down group drives low.
			// RQ3: bypass passes the clock
			// RQ8: power-down silences the group
			assign div_clk_out[g] = cfg[g].power_down ? 1'b0 :
				(cfg[g].bypass ? clock : level_q[g]);

			// RQ8: all three outputs float
			assign out_enable[g*`ODGC_OUTS_PER_GROUP +:
				`ODGC_OUTS_PER_GROUP] =
				{`ODGC_OUTS_PER_GROUP{~cfg[g].power_down}};

			// RQ9: correction unless disabled
			assign duty_cycle_correction_en[g] = ~cfg[g].dcc_off;
		end
	endgenerate

endmodule

// File: testbench/odgc_top_chk.sv
`timescale 1ns/1ps
`include "odgc_map.svh"
// Shadows the settings so that each output check knows the mode.
module odgc_chk
	import odgc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Bus.
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	// Dividers.
	input wire logic sync_hold,
	input wire logic [1:0] div_clk_out,
	input wire logic [5:0] out_enable,
	input wire logic [1:0] duty_cycle_correction_en
);
	logic [7:0] sh_q [6];
	logic [9:0] ix;
	logic [7:0] c2;
	logic [7:0] p2;
	assign ix = address[11:2] - `ODGC_IDX_DIV2_COUNTS;
	assign c2 = sh_q[1];
	assign p2 = sh_q[2];
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	// Stores on the slave's own edge, so the shadow never lags.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			sh_q <= '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		else if (write && !waitrequest && byteenable[0] && ix < 10'h006)
			sh_q[ix[2:0]] <= writedata[7:0];
	end
	wait_first_a: assert property ($rose(read || write) |-> waitrequest)
		else $error("no wait state");
	wait_one_a: assert property ((read || write) && waitrequest
		|=> !waitrequest) else $error("long wait");
	sync_park_a: assert property (
		sync_hold && $past(sync_hold) && $stable(c2) && c2[7:6] == 2'b00
		&& !p2[2] |-> !div_clk_out[0]) else $error("ran in hold");
	force_lvl_a: assert property (
		c2[7:5] == 3'b011 && $stable(c2) && !p2[2] |-> div_clk_out[0])
		else $error("not forced");
	byp_pass_a: assert property (@(negedge clock) disable iff (!reset_n)
		c2[7] && !p2[2] |-> div_clk_out[0]) else $error("no bypass");
	pwr_float_a: assert property (
		out_enable == {{3{!sh_q[5][2]}}, {3{!p2[2]}}})
		else $error("enable wrong");
	dcc_en_a: assert property (
		duty_cycle_correction_en == ~{sh_q[5][0], p2[0]})
		else $error("duty wrong");
	restart_a: assert property (
		$fell(sync_hold) && c2[7:6] == 2'b00 && c2[4:0] == 5'h10
		&& !p2[2] |-> !div_clk_out[0] [*2] ##1 div_clk_out[0])
		else $error("bad restart");
endmodule
bind odgc_top odgc_chk u_chk (.clock(clock), .reset_n(reset_n),
	.address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata),
	.waitrequest(waitrequest), .sync_hold(sync_hold),
	.div_clk_out(div_clk_out), .out_enable(out_enable),
	.duty_cycle_correction_en(duty_cycle_correction_en));

// File: testbench/odgc_top_tb.sv
`timescale 1ns/1ps
module odgc_top_tb
	import odgc_pkg::*;
;
	logic clock, reset_n, read, write, sync_hold, waitrequest;
	logic [11:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, rd;
	logic [1:0] div_clk_out, duty_cycle_correction_en;
	logic [5:0] out_enable;
	logic [7:0] t [4];
	int n_fail, comparisons, hi, lo, k;

	odgc_top DUT (.clock(clock), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sync_hold(sync_hold),
		.div_clk_out(div_clk_out), .out_enable(out_enable),
		.duty_cycle_correction_en(duty_cycle_correction_en));

	// Free-running 125 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic tally_and_finish;
		$display("checks %0d fails %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic die;
		n_fail++;
		tally_and_finish();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stp;
		@(posedge clock);
		#1;
	endtask

	// Holds the request until waitrequest is sampled low at a rising edge,
	// takes read data at that edge, then lets one idle edge pass.
	task automatic bus(input logic wr, input logic [9:0] ix,
		input logic [7:0] d);
		int w;
		w = 0;
		read <= !wr;
		write <= wr;
		address <= {ix, 2'b00};
		writedata <= {24'h000000, d};
		do
		begin
			@(posedge clock);
			w++;
		end
		while (waitrequest !== 1'b0 && w < 50);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		if (w >= 50)
			die();
	endtask

	task automatic rdchk(input logic [9:0] ix, input logic [7:0] e);
		bus(1'b0, ix, 8'h00);
		chk(rd, {24'h000000, e});
	endtask

	// Counts samples while the output stays at v; a stuck output ends the run.
	task automatic span(input int g, input logic v, output int n);
		n = 0;
		while (div_clk_out[g] === v && n < 40)
		begin
			stp();
			n++;
		end
		if (n >= 40)
			die();
	endtask

	task automatic meas(input int g);
		stp();
		span(g, 1'b1, k);
		span(g, 1'b0, k);
		span(g, 1'b1, hi);
		span(g, 1'b0, lo);
		@(posedge clock);
	endtask

	// Main sequence.
	initial
	begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		sync_hold = 1'b0;
		address = 12'h000;
		byteenable = 4'hF;
		writedata = 32'h00000000;
		n_fail = 0;
		comparisons = 0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 6; i++)
			rdchk(10'h196 + 10'(i), i == 0 ? 8'h11 : 8'h00);
		bus(1'b1, 10'h198, 8'hFF);
		rdchk(10'h198, 8'h05);
		chk(out_enable, 6'h38);
		chk(duty_cycle_correction_en, 2'b10);
		bus(1'b1, 10'h19B, 8'h05);
		chk(out_enable, 6'h00);
		chk(duty_cycle_correction_en, 2'b00);
		bus(1'b1, 10'h198, 8'h00);
		bus(1'b1, 10'h19B, 8'h00);
		byteenable <= 4'h0;
		bus(1'b1, 10'h199, 8'h77);
		byteenable <= 4'hF;
		bus(1'b1, 10'h1A0, 8'hFF);
		rdchk(10'h199, 8'h00);
		rdchk(10'h1A0, 8'h00);
		$display("test registers done");
		t = '{8'h11, 8'h0F, 8'hF0, 8'h3A};
		foreach (t[i])
		begin
			bus(1'b1, 10'h196, t[i]);
			meas(0);
			chk(hi, t[i][3:0] + 1);
			chk(lo, t[i][7:4] + 1);
		end
		meas(1);
		chk(hi, 1);
		chk(lo, 1);
		bus(1'b1, 10'h196, 8'h11);
		$display("test division done");
		t = '{8'h10, 8'h15, 8'h02, 8'h0F};
		foreach (t[i])
		begin
			bus(1'b1, 10'h197, t[i]);
			sync_hold <= 1'b1;
			repeat (4) stp();
			chk(div_clk_out[0], 1'b0);
			@(posedge clock);
			sync_hold <= 1'b0;
			stp();
			span(0, 1'b0, k);
			chk(k, t[i][3:0] + (t[i][4] ? 1 : 3));
			@(posedge clock);
		end
		$display("test sync done");
		bus(1'b1, 10'h197, 8'h40);
		sync_hold <= 1'b1;
		meas(0);
		chk(hi, 2);
		chk(div_clk_out[1], 1'b0);
		sync_hold <= 1'b0;
		bus(1'b1, 10'h197, 8'h60);
		repeat (3) stp();
		chk(div_clk_out[0], 1'b1);
		@(posedge clock);
		bus(1'b0, 10'h19C, 8'h00);
		chk(rd[1:0], 2'b01);
		bus(1'b1, 10'h197, 8'h20);
		meas(0);
		chk(hi, 2);
		$display("test force done");
		bus(1'b1, 10'h197, 8'h80);
		#2;
		chk(div_clk_out[0], 1'b1);
		@(negedge clock);
		#2;
		chk(div_clk_out[0], 1'b0);
		$display("test bypass done");
		tally_and_finish();
	end
endmodule
